// ==== rtl/tmr_ctrl.sv ====
// Purpose: control, capture and reload logic of a 16-bit general timer
// Assumes: pins asynchronous to ref_clk in timing, so resampled here
// Notes: one clock domain; flags set by hardware win over software
//
// Overview of operation
// RQ1: overflow flag set on FFFF to 0000 wrap
// RQ2: overflow flag never set in baud mode
// RQ3: software writing overflow flag raises interrupt
// RQ4: trigger falling edge sets external-event flag; the code does not set it in baud mode
// RQ5: external-event flag requests interrupt; software clears
// RQ6: software writing external-event flag raises interrupt
// RQ7: receive clock: this timer or other timer
// RQ8: transmit clock: this timer or other timer
// RQ9: enabled trigger edge captures or reloads, not baud
// RQ10: trigger disabled: pin transitions fully ignored
// RQ11: run bit gates increments; count holds
// RQ12: timer source counts every four or twelve clocks
// RQ13: baud mode counts every two clocks
// RQ14: event source counts event pin falling edges
// RQ15: capture select one: capture on trigger edge
// RQ16: capture select zero: reload on overflow, trigger
// RQ17: baud mode always reloads on overflow
// RQ18: capture copies count bytes into holding bytes
// RQ19: reload loads count from holding bytes
// RQ20: baud overflow divided by sixteen for uart
// RQ21: pins synchronised, falling edges by sample compare
// RQ22: hardware flag set beats same-cycle software write
module tmr_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // special-register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // pins and neighbours
    input wire logic trigger_input_pin,
    input wire logic event_count_pin,
    input wire logic prescale_select,
    input wire logic other_timer_ovf,
    input wire logic timer_int_enable,
    // outputs
    output logic timer_irq,
    output logic uart_rx_clk,
    output logic uart_tx_clk
);
    import tmr_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] ctrl_ff;
    logic [15:0] count_ff;
    logic [15:0] hold_ff;
    logic [3:0] pre_cnt_ff;
    logic [3:0] baud_div_ff;
    logic [2:0] trig_sync_ff;
    logic [2:0] evt_sync_ff;
    logic [7:0] rdata_ff;
    logic rx_clk_ff;
    logic tx_clk_ff;

    function automatic logic [15:0] put_byte(input logic [15:0] word, input logic hi,
                                             input logic lo, input logic [7:0] data);
        put_byte = {hi ? data : word[15:8], lo ? data : word[7:0]};
    endfunction : put_byte

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire wr_ctrl = sfr_wr && (sfr_addr == TMR_ADDR_CTRL);
    wire wr_hold_lo = sfr_wr && (sfr_addr == TMR_ADDR_HOLD_LO);
    wire wr_hold_hi = sfr_wr && (sfr_addr == TMR_ADDR_HOLD_HI);
    wire wr_cnt_lo = sfr_wr && (sfr_addr == TMR_ADDR_CNT_LO);
    wire wr_cnt_hi = sfr_wr && (sfr_addr == TMR_ADDR_CNT_HI);
    wire wr_cnt = wr_cnt_lo || wr_cnt_hi;

    wire overflow_flag = ctrl_ff[TMR_BIT_OVF];
    wire external_event_flag = ctrl_ff[TMR_BIT_EXT];
    wire uart_rx_clock_select = ctrl_ff[TMR_BIT_RXSEL];
    wire uart_tx_clock_select = ctrl_ff[TMR_BIT_TXSEL];
    wire external_trigger_enable = ctrl_ff[TMR_BIT_TRIGEN];
    wire run_control = ctrl_ff[TMR_BIT_RUN];
    wire count_source_select = ctrl_ff[TMR_BIT_SRC];
    wire capture_reload_select = ctrl_ff[TMR_BIT_CAPSEL];
    wire baud_mode = uart_rx_clock_select || uart_tx_clock_select;

    // ---------------------------------------------------------------
    // pin edges
    // ---------------------------------------------------------------
    // stage 0 only feeds stage 1, so metastability never reaches the compare
    wire trig_fall = trig_sync_ff[2] && !trig_sync_ff[1]; // RQ21
    wire evt_fall = evt_sync_ff[2] && !evt_sync_ff[1]; // RQ21

    // ---------------------------------------------------------------
    // increment source
    // ---------------------------------------------------------------
    wire [3:0] pre_last = baud_mode ? TMR_PRE_LAST_2 : // RQ13
                          prescale_select ? TMR_PRE_LAST_4 : TMR_PRE_LAST_12; // RQ12
    // >= lets the divider recover at once when the mode shortens it
    wire pre_tick = pre_cnt_ff >= pre_last;
    wire [3:0] nxt_pre_cnt = pre_tick ? 4'h0 : pre_cnt_ff + 4'h1;
    wire inc = run_control && (count_source_select ? evt_fall : pre_tick); // RQ11 RQ14
    wire ovf = inc && (count_ff == TMR_CNT_MAX);

    // ---------------------------------------------------------------
    // capture and reload
    // ---------------------------------------------------------------
    wire trig_evt = external_trigger_enable && !baud_mode && trig_fall; // RQ9 RQ10
    wire capture = trig_evt && capture_reload_select; // RQ15
    wire reload = (ovf && (baud_mode || !capture_reload_select)) // RQ16 RQ17
                  || (trig_evt && !capture_reload_select); // RQ16
    wire [15:0] cnt_hw = reload ? hold_ff : inc ? count_ff + 16'h0001 : count_ff; // RQ19
    wire [15:0] nxt_count = put_byte(cnt_hw, wr_cnt_hi, wr_cnt_lo, sfr_wdata);
    wire [15:0] hold_sw = put_byte(hold_ff, wr_hold_hi, wr_hold_lo, sfr_wdata);
    wire [15:0] nxt_hold = capture ? count_ff : hold_sw; // RQ18

    // ---------------------------------------------------------------
    // control register and flags
    // ---------------------------------------------------------------
    wire [7:0] ctrl_sw = wr_ctrl ? sfr_wdata : ctrl_ff;
    wire ovf_set = ovf && !baud_mode; // RQ1 RQ2
    wire nxt_ovf_flag = ovf_set || ctrl_sw[TMR_BIT_OVF]; // RQ22
    wire nxt_ext_flag = trig_evt || ctrl_sw[TMR_BIT_EXT]; // RQ4 RQ22
    wire [7:0] nxt_ctrl = {nxt_ovf_flag, nxt_ext_flag, ctrl_sw[5:0]};

    // ---------------------------------------------------------------
    // uart clocks
    // ---------------------------------------------------------------
    wire baud_ovf = ovf && baud_mode;
    wire [3:0] nxt_baud_div = baud_ovf ? baud_div_ff + 4'h1 : baud_div_ff;
    wire baud_pulse = baud_ovf && (baud_div_ff == TMR_BAUD_LAST); // RQ20
    wire nxt_rx_clk = uart_rx_clock_select ? baud_pulse : other_timer_ovf; // RQ7
    wire nxt_tx_clk = uart_tx_clock_select ? baud_pulse : other_timer_ovf; // RQ8

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    wire [7:0] rd_mux = (sfr_addr == TMR_ADDR_CTRL) ? ctrl_ff :
                        (sfr_addr == TMR_ADDR_HOLD_LO) ? hold_ff[7:0] :
                        (sfr_addr == TMR_ADDR_HOLD_HI) ? hold_ff[15:8] :
                        (sfr_addr == TMR_ADDR_CNT_LO) ? count_ff[7:0] :
                        (sfr_addr == TMR_ADDR_CNT_HI) ? count_ff[15:8] : 8'h00;
    wire [7:0] nxt_rdata = sfr_rd ? rd_mux : 8'h00;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff <= TMR_CTRL_RST;
            count_ff <= TMR_CNT_RST;
            hold_ff <= TMR_HOLD_RST;
            pre_cnt_ff <= 4'h0;
            baud_div_ff <= 4'h0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            count_ff <= nxt_count;
            hold_ff <= nxt_hold;
            pre_cnt_ff <= nxt_pre_cnt;
            baud_div_ff <= nxt_baud_div;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            trig_sync_ff <= 3'h7;
            evt_sync_ff <= 3'h7;
            rdata_ff <= 8'h00;
            rx_clk_ff <= 1'b0;
            tx_clk_ff <= 1'b0;
        end
        else
        begin
            trig_sync_ff <= {trig_sync_ff[1:0], trigger_input_pin}; // RQ21
            evt_sync_ff <= {evt_sync_ff[1:0], event_count_pin}; // RQ21
            rdata_ff <= nxt_rdata;
            rx_clk_ff <= nxt_rx_clk;
            tx_clk_ff <= nxt_tx_clk;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // a software write of 1 to either flag lands here like a hardware set
    assign timer_irq = timer_int_enable && (overflow_flag || external_event_flag); // RQ3 RQ5 RQ6
    assign sfr_rdata = rdata_ff;
    assign uart_rx_clk = rx_clk_ff;
    assign uart_tx_clk = tx_clk_ff;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_ovf_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ1
        (inc && count_ff == TMR_CNT_MAX && !baud_mode) |=> overflow_flag)
        else $error("overflow flag not set on wrap");
    a_ovf_baud_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
        $rose(overflow_flag) |-> $past(!baud_mode) || $past(wr_ctrl && sfr_wdata[7]))
        else $error("overflow flag set in baud mode");
    a_irq_on_write: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ3
        (wr_ctrl && sfr_wdata[7]) ##1 timer_int_enable |-> timer_irq)
        else $error("flag write did not raise interrupt");
    a_ext_flag_set: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ4
        (external_trigger_enable && !baud_mode && trig_fall) |=> external_event_flag)
        else $error("external event flag not set");
    a_ext_irq_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ5
        (external_event_flag && !wr_ctrl) |=> external_event_flag)
        else $error("external event flag cleared by hardware");
    a_trig_ignored: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ10
        (!external_trigger_enable && !wr_ctrl && !wr_hold_lo && !wr_hold_hi)
        |=> !$rose(external_event_flag) && $stable(hold_ff))
        else $error("disabled trigger had an effect");
    a_run_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ11
        (!run_control && !wr_cnt && !reload) |=> $stable(count_ff))
        else $error("count moved while stopped");
    a_baud_rate: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ13
        (pre_tick && baud_mode) ##1 baud_mode[*2] |-> pre_tick && $past(!pre_tick))
        else $error("baud mode tick not every two clocks");
    a_capture_copy: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ18
        capture |=> hold_ff == $past(count_ff))
        else $error("capture did not copy count");
    a_reload_load: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ19
        (reload && !wr_cnt) |=> count_ff == $past(hold_ff))
        else $error("reload did not load holding value");
    a_rx_clk_sel: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ7
        !uart_rx_clock_select |=> uart_rx_clk == $past(other_timer_ovf))
        else $error("receive clock not from other timer");

    // ---------------------------------------------------------------
    // flag and interrupt checks
    // ---------------------------------------------------------------
    a_ext_irq_req: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ5
        (timer_int_enable && external_event_flag) |-> timer_irq)
        else $error("external event flag did not request interrupt");
    a_ext_write_irq: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ6
        (wr_ctrl && sfr_wdata[TMR_BIT_EXT]) ##1 timer_int_enable |-> timer_irq)
        else $error("external flag write did not raise interrupt");
    a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ3
        (!timer_int_enable || (!overflow_flag && !external_event_flag)) |-> !timer_irq)
        else $error("interrupt raised without enabled flag");
    a_hw_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ22
        (ovf_set || trig_evt) |=> (overflow_flag || !$past(ovf_set))
        && (external_event_flag || !$past(trig_evt)))
        else $error("software write beat a hardware flag set");
    a_ext_flag_only: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ4
        $rose(external_event_flag) |-> $past(trig_evt) || $past(wr_ctrl && sfr_wdata[TMR_BIT_EXT]))
        else $error("external event flag set without trigger");

    // ---------------------------------------------------------------
    // count, capture and reload checks
    // ---------------------------------------------------------------
    a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ1
        (ovf && !reload && !wr_cnt) |=> count_ff == TMR_CNT_RST)
        else $error("count did not wrap to zero");
    a_trig_action: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ9
        (external_trigger_enable && !baud_mode && trig_fall) |-> capture || reload)
        else $error("enabled trigger edge did nothing");
    a_tick_four: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ12
        (pre_tick && !baud_mode && prescale_select)
        ##1 (!baud_mode && prescale_select)[*4] |-> pre_tick)
        else $error("timer tick not every four clocks");
    a_tick_twelve: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ12
        (pre_tick && !baud_mode && !prescale_select)
        ##1 (!baud_mode && !prescale_select)[*8]
        ##1 (!baud_mode && !prescale_select)[*4] |-> pre_tick)
        else $error("timer tick not every twelve clocks");
    a_timer_inc: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ12
        (run_control && !count_source_select && pre_tick && !reload && !wr_cnt)
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("timer tick did not increment count");
    a_event_inc: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ14
        (run_control && count_source_select && evt_fall && !reload && !wr_cnt)
        |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("event edge did not increment count");
    a_event_only: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ14
        (count_source_select && !evt_fall && !reload && !wr_cnt)
        |=> $stable(count_ff))
        else $error("event source counted without an edge");
    a_capture_mode: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ15
        (capture_reload_select && !baud_mode) |-> !reload)
        else $error("reload in capture mode");
    a_ovf_reload: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ16
        (ovf && !capture_reload_select && !wr_cnt) |=> count_ff == $past(hold_ff))
        else $error("overflow did not reload in reload mode");
    a_baud_reload: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ17
        (ovf && baud_mode && !wr_cnt) |=> count_ff == $past(hold_ff))
        else $error("overflow did not reload in baud mode");
    a_pin_edge: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ21
        trig_fall |-> $past(trigger_input_pin, 3) && !$past(trigger_input_pin, 2))
        else $error("trigger edge without falling pin");

    // ---------------------------------------------------------------
    // uart clock checks
    // ---------------------------------------------------------------
    a_tx_clk_sel: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8
        !uart_tx_clock_select |=> uart_tx_clk == $past(other_timer_ovf))
        else $error("transmit clock not from other timer");
    a_rx_clk_baud: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ7
        uart_rx_clock_select |=> uart_rx_clk == $past(baud_ovf && baud_div_ff == TMR_BAUD_LAST))
        else $error("receive clock not from this timer");
    a_tx_clk_baud: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8
        uart_tx_clock_select |=> uart_tx_clk == $past(baud_ovf && baud_div_ff == TMR_BAUD_LAST))
        else $error("transmit clock not from this timer");
    a_baud_div_step: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ20
        baud_ovf |=> baud_div_ff == $past(baud_div_ff) + 4'h1)
        else $error("baud divider did not step on overflow");
    a_baud_div_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ20
        !baud_ovf |=> $stable(baud_div_ff))
        else $error("baud divider moved without overflow");
endmodule : tmr_ctrl

// ==== rtl/tmr_pkg.sv ====
// Purpose: shared constants for the general timer control block
// Assumes: 8-bit special-register bus, 200 MHz cpu clock
// Notes: bit positions follow the control register layout
package tmr_pkg;
    // ---------------------------------------------------------------
    // register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] TMR_ADDR_CTRL = 8'hC8;
    localparam logic [7:0] TMR_ADDR_HOLD_LO = 8'hCA;
    localparam logic [7:0] TMR_ADDR_HOLD_HI = 8'hCB;
    localparam logic [7:0] TMR_ADDR_CNT_LO = 8'hCC;
    localparam logic [7:0] TMR_ADDR_CNT_HI = 8'hCD;
    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int TMR_BIT_OVF = 7;
    localparam int TMR_BIT_EXT = 6;
    localparam int TMR_BIT_RXSEL = 5;
    localparam int TMR_BIT_TXSEL = 4;
    localparam int TMR_BIT_TRIGEN = 3;
    localparam int TMR_BIT_RUN = 2;
    localparam int TMR_BIT_SRC = 1;
    localparam int TMR_BIT_CAPSEL = 0;
    // ---------------------------------------------------------------
    // reset values and maximum count
    // ---------------------------------------------------------------
    localparam logic [7:0] TMR_CTRL_RST = 8'h00;
    localparam logic [15:0] TMR_CNT_RST = 16'h0000;
    localparam logic [15:0] TMR_HOLD_RST = 16'h0000;
    localparam logic [15:0] TMR_CNT_MAX = 16'hFFFF;
    // ---------------------------------------------------------------
    // timing counts, as last index of each divider
    // ---------------------------------------------------------------
    localparam logic [3:0] TMR_PRE_LAST_12 = 4'hB;
    localparam logic [3:0] TMR_PRE_LAST_4 = 4'h3;
    localparam logic [3:0] TMR_PRE_LAST_2 = 4'h1;
    localparam logic [3:0] TMR_BAUD_LAST = 4'hF;
endpackage : tmr_pkg

// ==== tb/tb_tmr_ctrl.sv ====
// Purpose: self-checking bench for the timer control block
// Assumes: inputs driven at the falling edge, read data one cycle late
// Notes: counts are compared over windows that are whole divider periods
module tb_tmr_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import tmr_pkg::*;
    logic ref_clk, rstn, sfr_wr, sfr_rd, prescale_select, timer_int_enable;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    wire logic trig, evt, other_ovf, irq, rx_clk, tx_clk;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // ---------------------------------------------------------------
    // design and far side
    // ---------------------------------------------------------------
    tmr_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .trigger_input_pin(trig), .event_count_pin(evt), .prescale_select(prescale_select),
        .other_timer_ovf(other_ovf), .timer_int_enable(timer_int_enable),
        .timer_irq(irq), .uart_rx_clk(rx_clk), .uart_tx_clk(tx_clk));
    tmr_far_model far (.ref_clk(ref_clk), .rstn(rstn), .uart_rx_clk(rx_clk),
        .uart_tx_clk(tx_clk), .trigger_input_pin(trig), .event_count_pin(evt),
        .other_timer_ovf(other_ovf));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rc
    // ---------------------------------------------------------------
    // clock, timeout and tests
    // ---------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // the tests need about 10000 cycles; a hang is cut well after that
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        logic [7:0] v1;
        logic [7:0] v2;
        int r0;
        int t0;
        rstn = 1'b0;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h00000;
        prescale_select = 1'b1;
        timer_int_enable = 1'b1;
        idle(5);
        rstn = 1'b1;
        rc(TMR_ADDR_CTRL, 8'h00);
        rc(TMR_ADDR_HOLD_LO, 8'h00);
        rc(TMR_ADDR_CNT_HI, 8'h00);
        wr(8'hC9, 8'hFF);
        rc(8'hC9, 8'h00);
        wr(TMR_ADDR_CTRL, 8'h80);
        chk({7'h00, irq}, 8'h01);
        timer_int_enable = 1'b0;
        idle(1);
        chk({7'h00, irq}, 8'h00);
        timer_int_enable = 1'b1;
        wr(TMR_ADDR_CTRL, 8'h40);
        chk({7'h00, irq}, 8'h01);
        wr(TMR_ADDR_CTRL, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(TMR_ADDR_CNT_LO, 8'h34);
        idle(40);
        rc(TMR_ADDR_CNT_LO, 8'h34);
        wr(TMR_ADDR_CNT_LO, 8'h00);
        wr(TMR_ADDR_CTRL, 8'h04);
        for (int p = 0; p < 2; p++)
        begin
            prescale_select = p[0];
            idle(12);
            rd(TMR_ADDR_CNT_LO, v1);
            idle(46);
            rd(TMR_ADDR_CNT_LO, v2);
            chk(8'(v2 - v1), p ? 8'h0C : 8'h04);
        end
        prescale_select = 1'b1;
        wr(TMR_ADDR_HOLD_LO, 8'hF0);
        wr(TMR_ADDR_HOLD_HI, 8'hFF);
        for (int c = 0; c < 2; c++)
        begin
            wr(TMR_ADDR_CNT_LO, 8'hF0);
            wr(TMR_ADDR_CNT_HI, 8'hFF);
            wr(TMR_ADDR_CTRL, 8'h04 | 8'(c));
            idle(100);
            rc(TMR_ADDR_CTRL, 8'h84 | 8'(c));
            rc(TMR_ADDR_CNT_HI, c ? 8'h00 : 8'hFF);
            wr(TMR_ADDR_CTRL, 8'h00);
        end
        wr(TMR_ADDR_CNT_LO, 8'h3C);
        wr(TMR_ADDR_CNT_HI, 8'h5A);
        wr(TMR_ADDR_CTRL, 8'h01);
        far.fall(1'b1);
        rc(TMR_ADDR_HOLD_LO, 8'hF0);
        rc(TMR_ADDR_CTRL, 8'h01);
        wr(TMR_ADDR_CTRL, 8'h09);
        far.fall(1'b1);
        rc(TMR_ADDR_HOLD_LO, 8'h3C);
        rc(TMR_ADDR_HOLD_HI, 8'h5A);
        rc(TMR_ADDR_CTRL, 8'h49);
        chk({7'h00, irq}, 8'h01);
        wr(TMR_ADDR_CNT_LO, 8'h00);
        wr(TMR_ADDR_CTRL, 8'h08);
        far.fall(1'b1);
        rc(TMR_ADDR_CNT_LO, 8'h3C);
        rc(TMR_ADDR_CTRL, 8'h48);
        wr(TMR_ADDR_CNT_LO, 8'h00);
        wr(TMR_ADDR_CTRL, 8'h06);
        repeat (5) far.fall(1'b0);
        rc(TMR_ADDR_CNT_LO, 8'h05);
        wr(TMR_ADDR_HOLD_LO, 8'hF0);
        wr(TMR_ADDR_HOLD_HI, 8'hFF);
        wr(TMR_ADDR_CNT_LO, 8'hF0);
        wr(TMR_ADDR_CNT_HI, 8'hFF);
        // baud: 16 steps of 2 clocks per overflow, 16 overflows per uart pulse
        // second pass sets capture select, which baud mode must ignore
        for (int s = 0; s < 2; s++)
        begin
            wr(TMR_ADDR_CTRL, s ? 8'h1D : 8'h2C);
            idle(600);
            r0 = far.n_rx;
            t0 = far.n_tx;
            idle(4096);
            chk(8'(far.n_rx - r0), s ? 8'h40 : 8'h08);
            chk(8'(far.n_tx - t0), s ? 8'h08 : 8'h40);
            far.fall(1'b1);
            rc(TMR_ADDR_CTRL, s ? 8'h1D : 8'h2C);
        end
        close_out();
    end
endmodule : tb_tmr_ctrl

// ==== tb/tmr_far_model.sv ====
// Purpose: far side of the timer: pins, other timer pulses, uart clock counts
// Assumes: both pins pulled high when idle
// Notes: pin levels are held 3 cycles, above the 2-cycle minimum
module tmr_far_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // uart clock inputs
    input wire logic uart_rx_clk,
    input wire logic uart_tx_clk,
    // pins and other timer
    output logic trigger_input_pin,
    output logic event_count_pin,
    output logic other_timer_ovf
);
    timeunit 1ns;
    timeprecision 100ps;
    int n_rx = 0;
    int n_tx = 0;
    int ph = 0;
    initial
    begin
        trigger_input_pin = 1'b1;
        event_count_pin = 1'b1;
        other_timer_ovf = 1'b0;
    end
    // other timer overflows every 64 cycles, one cycle wide
    always @(negedge ref_clk)
    begin
        ph = (ph + 1) % 64;
        other_timer_ovf = (ph == 0) && rstn;
    end
    // non-blocking counts so the bench can read them at any falling edge
    always @(posedge ref_clk)
    begin
        n_rx <= n_rx + int'(uart_rx_clk === 1'b1);
        n_tx <= n_tx + int'(uart_tx_clk === 1'b1);
    end
    // one falling edge on the trigger pin (trig=1) or the event pin
    task automatic fall(input logic trig);
        @(negedge ref_clk);
        if (trig)
            trigger_input_pin = 1'b0;
        else
            event_count_pin = 1'b0;
        repeat (3) @(negedge ref_clk);
        trigger_input_pin = 1'b1;
        event_count_pin = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : fall
endmodule : tmr_far_model
